// >>> hdl/dlsn_regs.svh
/*
 * Register offsets, field positions, reset values and opcode constants
 * for the double-length shift and normalize unit.
 * Assumes an 8-bit byte address on the register port, one 24-bit word per
 * aligned 32-bit slot.
 */
`ifndef DLSN_REGS_SVH
`define DLSN_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DLSN_OFF_ACC      8'h00
`define DLSN_OFF_EXT      8'h04
`define DLSN_OFF_IDX      8'h08
`define DLSN_OFF_STAT     8'h0c
`define DLSN_OFF_MASK     8'h10
`define DLSN_OFF_FLAG     8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DLSN_STAT_DONE    0
`define DLSN_STAT_OVF     1
`define DLSN_FLAG_OVF     0
`define DLSN_FLAG_BUSY    1
`define DLSN_SIGN_BIT     23
`define DLSN_NORM_BIT     22
`define DLSN_METH_HI      13
`define DLSN_METH_LO      12
`define DLSN_CNT_HI       5

// ----------------------------------------------------------------------
// Opcodes and method patterns
// ----------------------------------------------------------------------
`define DLSN_OPC_RIGHT    6'h36
`define DLSN_OPC_LEFT     6'h37
`define DLSN_METH_SHIFT   2'h0
`define DLSN_METH_CYCLE   2'h2
`define DLSN_METH_NORM    2'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DLSN_WORD_RST     24'h000000
`define DLSN_EVT_RST      2'h0
`define DLSN_CNT_RST      6'h00

`endif

// >>> hdl/dlsn_pkg.sv
/*
 * Types and shared functions of the shift and normalize unit.
 * Assumes dlsn_regs.svh is on the include path.
 */
`include "dlsn_regs.svh"

package dlsn_pkg;

    // ------------------------------------------------------------------
    // Operation and sequence types
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OP_ARS  = 3'h0,
        OP_RROT = 3'h1,
        OP_LSH  = 3'h2,
        OP_LROT = 3'h3,
        OP_NORM = 3'h4,
        OP_NONE = 3'h5
    } dlsn_op_t;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'h0,
        ST_SET1  = 2'h1,
        ST_SET2  = 2'h3,
        ST_SHIFT = 2'h2
    } dlsn_state_t;

    typedef struct packed
    {
        dlsn_state_t st;
        dlsn_op_t    op;
        logic [5:0]  cnt;
        logic [23:0] acc;
        logic [23:0] ext;
        logic [23:0] idx;
        logic        sign;
        logic        ovf;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        done;
        logic        busy;
        logic        irq;
        logic [23:0] rdata;
    } dlsn_state_reg_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic dlsn_is_norm(input logic [23:0] w);
        return w[`DLSN_NORM_BIT] != w[`DLSN_SIGN_BIT];
    endfunction

endpackage

// >>> hdl/dlsn_dec_if.sv
/*
 * Decoded operation carried from the instruction decoder to the core.
 * Assumes both ends run on clk_sys; the content is combinational.
 */
`timescale 1ns/1ps
`default_nettype none

interface dlsn_dec_if
    import dlsn_pkg::*;
();
    dlsn_op_t   op;
    logic [5:0] count;

    modport dec  (output op, count);
    modport core (input op, count);
endinterface

`default_nettype wire

// >>> hdl/dlsn_decode.sv
/*
 * Instruction decoder: effective address forming and method selection.
 * Assumes the sequencer holds its request inputs stable while start is high.
 */
`timescale 1ns/1ps
`default_nettype none

module dlsn_decode
    import dlsn_pkg::*;
(
    // Sequencer request
    input  wire logic [5:0]  opcode,
    input  wire logic [13:0] addr_field,
    input  wire logic        indexed,
    input  wire logic        indirect,
    input  wire logic [13:0] indirect_word,
    // Index low bits
    input  wire logic [5:0]  idx_low,
    // Decoded operation
    dlsn_dec_if.dec          bus
);

    logic [13:0] ea;
    logic [1:0]  meth;

    always_comb
    begin
        ea = addr_field;
        if (indirect)
        begin
            ea = indirect_word;
        end
        else if (indexed)
        begin
            // Carry stays inside the count field
            ea = {addr_field[13:6], addr_field[5:0] + idx_low};
        end
        meth = ea[`DLSN_METH_HI:`DLSN_METH_LO];
        bus.count = ea[`DLSN_CNT_HI:0];
        bus.op = OP_NONE;
        if (opcode == `DLSN_OPC_RIGHT)
        begin
            if (meth == `DLSN_METH_SHIFT)
            begin
                bus.op = OP_ARS;
            end
            else if (meth == `DLSN_METH_CYCLE)
            begin
                bus.op = OP_RROT;
            end
        end
        else if (opcode == `DLSN_OPC_LEFT)
        begin
            if (meth == `DLSN_METH_SHIFT)
            begin
                bus.op = OP_LSH;
            end
            else if (meth == `DLSN_METH_CYCLE)
            begin
                bus.op = OP_LROT;
            end
            else if (meth == `DLSN_METH_NORM)
            begin
                bus.op = OP_NORM;
            end
        end
    end

endmodule

`default_nettype wire

// >>> hdl/dlsn_step.sv
/*
 * One-position move of the 48-bit pair for every method.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module dlsn_step
    import dlsn_pkg::*;
(
    // Operation
    input  wire dlsn_op_t    op,
    input  wire logic        sign,
    // Pair in
    input  wire logic [23:0] acc_in,
    input  wire logic [23:0] ext_in,
    // Pair out
    output logic [23:0]      acc_out,
    output logic [23:0]      ext_out,
    output logic             ovf_hit
);

    always_comb
    begin
        acc_out = acc_in;
        ext_out = ext_in;
        ovf_hit = 1'b0;
        unique case (op)
            OP_ARS:
            begin
                acc_out = {acc_in[23], acc_in[23:1]};
                ext_out = {acc_in[0], ext_in[23:1]};
            end
            OP_RROT:
            begin
                acc_out = {ext_in[0], acc_in[23:1]};
                ext_out = {acc_in[0], ext_in[23:1]};
            end
            OP_LSH, OP_NORM:
            begin
                acc_out = {acc_in[22:0], ext_in[23]};
                ext_out = {ext_in[22:0], 1'b0};
                ovf_hit = (op == OP_LSH) && (acc_in[22] != sign);
            end
            OP_LROT:
            begin
                acc_out = {acc_in[22:0], ext_in[23]};
                ext_out = {ext_in[22:0], acc_in[23]};
            end
            OP_NONE:
            begin
            end
            default:
            begin
            end
        endcase
    end

endmodule

`default_nettype wire

// >>> hdl/dlsn_unit.sv
/*
 * Double-length shift and normalize unit: sequence, pair registers,
 * index register, overflow indicator, register port and interrupt.
 * Assumes the instruction sequencer drives start for one cycle while idle
 * and waits for done; all inputs are synchronous to clk_sys.
 */
// Added by the designer: strobed register access and the register addresses.
// Functional notes
// - Pair is two 24-bit registers, chained
// - Opcode 66 right, 67 left
// - Address bits 10,11 pick method
// - Indexing touches only count bits
// - Indirection resolves all 14 bits
// - Six-bit count, zero means no move
// - Shift and rotate take 2+N cycles
// - Arithmetic right keeps and replicates sign
// - Right rotate forms a 48-bit ring
// - Left shift flags sign change overflow
// - Left rotate forms a 48-bit ring
// - Normalize until bit 1 differs, index down
// - Zero pair keeps shifting until count ends
// - Normalize takes 2+R cycles, count bounds
`timescale 1ns/1ps
`default_nettype none

module dlsn_unit
    import dlsn_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Sequencer request
    input  wire logic        start,
    input  wire logic [5:0]  opcode,
    input  wire logic [13:0] addr_field,
    input  wire logic        indexed,
    input  wire logic        indirect,
    input  wire logic [13:0] indirect_word,
    // Sequencer answer
    output logic             busy,
    output logic             done,
    output logic             overflow_flag,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [23:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [23:0]      rd_data,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam dlsn_state_reg_t RST_VAL = '{
        st:    ST_IDLE,
        op:    OP_NONE,
        cnt:   `DLSN_CNT_RST,
        acc:   `DLSN_WORD_RST,
        ext:   `DLSN_WORD_RST,
        idx:   `DLSN_WORD_RST,
        sign:  1'b0,
        ovf:   1'b0,
        stat:  `DLSN_EVT_RST,
        mask:  `DLSN_EVT_RST,
        done:  1'b0,
        busy:  1'b0,
        irq:   1'b0,
        rdata: `DLSN_WORD_RST
    };

    dlsn_state_reg_t state_reg;
    dlsn_state_reg_t state_next;

    logic [23:0] step_acc;
    logic [23:0] step_ext;
    logic        step_ovf;
    logic        ev_done;
    logic        ev_ovf;
    logic        finish;
    logic        sw_write;

    dlsn_dec_if dec_bus();

    // ------------------------------------------------------------------
    // Decoder and one-position datapath
    // ------------------------------------------------------------------
    dlsn_decode u_decode (
        .opcode        (opcode),
        .addr_field    (addr_field),
        .indexed       (indexed),
        .indirect      (indirect),
        .indirect_word (indirect_word),
        .idx_low       (state_reg.idx[5:0]),
        .bus           (dec_bus.dec)
    );

    dlsn_step u_step (
        .op      (state_reg.op),
        .sign    (state_reg.sign),
        .acc_in  (state_reg.acc),
        .ext_in  (state_reg.ext),
        .acc_out (step_acc),
        .ext_out (step_ext),
        .ovf_hit (step_ovf)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.rdata = `DLSN_WORD_RST;
        ev_done = 1'b0;
        ev_ovf = 1'b0;
        finish = 1'b0;
        // Pair and index are frozen to software while an operation runs
        sw_write = wr_en && (state_reg.st == ST_IDLE) && !start;

        unique case (state_reg.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    state_next.op = dec_bus.op;
                    // Undefined method moves nothing
                    state_next.cnt = (dec_bus.op == OP_NONE) ? `DLSN_CNT_RST
                                                             : dec_bus.count;
                    state_next.sign = state_reg.acc[`DLSN_SIGN_BIT];
                    state_next.st = ST_SET1;
                end
            end
            ST_SET1:
            begin
                state_next.st = ST_SET2;
            end
            ST_SET2:
            begin
                if ((state_reg.cnt == `DLSN_CNT_RST)
                    || ((state_reg.op == OP_NORM) && dlsn_is_norm(state_reg.acc)))
                begin
                    finish = 1'b1;
                end
                else
                begin
                    state_next.st = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                state_next.acc = step_acc;
                state_next.ext = step_ext;
                state_next.cnt = state_reg.cnt - 6'h01;
                ev_ovf = step_ovf;
                if (state_reg.op == OP_NORM)
                begin
                    state_next.idx = state_reg.idx - 24'h000001;
                end
                // A zero pair never normalizes, so only the count ends it
                if ((state_next.cnt == `DLSN_CNT_RST)
                    || ((state_reg.op == OP_NORM) && dlsn_is_norm(step_acc)))
                begin
                    finish = 1'b1;
                end
            end
        endcase

        if (finish)
        begin
            state_next.st = ST_IDLE;
            state_next.done = 1'b1;
            ev_done = 1'b1;
        end

        // Register writes
        if (sw_write)
        begin
            unique case (reg_addr)
                `DLSN_OFF_ACC:  state_next.acc = wr_data;
                `DLSN_OFF_EXT:  state_next.ext = wr_data;
                `DLSN_OFF_IDX:  state_next.idx = wr_data;
                `DLSN_OFF_MASK: state_next.mask = wr_data[1:0];
                default:
                begin
                end
            endcase
        end
        // Clears are accepted while busy; a same-cycle set wins
        if (wr_en && (reg_addr == `DLSN_OFF_STAT))
        begin
            state_next.stat = state_reg.stat & ~wr_data[1:0];
        end
        if (wr_en && (reg_addr == `DLSN_OFF_FLAG) && wr_data[`DLSN_FLAG_OVF])
        begin
            state_next.ovf = 1'b0;
        end
        if (ev_ovf)
        begin
            state_next.ovf = 1'b1;
            state_next.stat[`DLSN_STAT_OVF] = 1'b1;
        end
        if (ev_done)
        begin
            state_next.stat[`DLSN_STAT_DONE] = 1'b1;
        end
        state_next.irq = |(state_next.stat & state_next.mask);
        state_next.busy = (state_next.st != ST_IDLE);

        // Register reads, data valid in the following cycle only
        if (rd_en)
        begin
            unique case (reg_addr)
                `DLSN_OFF_ACC:  state_next.rdata = state_reg.acc;
                `DLSN_OFF_EXT:  state_next.rdata = state_reg.ext;
                `DLSN_OFF_IDX:  state_next.rdata = state_reg.idx;
                `DLSN_OFF_STAT: state_next.rdata = {22'h000000, state_reg.stat};
                `DLSN_OFF_MASK: state_next.rdata = {22'h000000, state_reg.mask};
                `DLSN_OFF_FLAG: state_next.rdata = {22'h000000, state_reg.busy,
                                                    state_reg.ovf};
                default:        state_next.rdata = `DLSN_WORD_RST;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= RST_VAL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign busy          = state_reg.busy;
    assign done          = state_reg.done;
    assign overflow_flag = state_reg.ovf;
    assign rd_data       = state_reg.rdata;
    assign irq           = state_reg.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence setup_seq;
        (state_reg.st == ST_SET1) ##1 (state_reg.st == ST_SET2);
    endsequence

    sequence take_seq;
        start && (state_reg.st == ST_IDLE);
    endsequence

    zero_count_done_a: assert property (
        take_seq and (dec_bus.count == 6'h00)
        |=> setup_seq ##1 (done && (state_reg.st == ST_IDLE)))
        else $error("zero count did not finish after setup");

    setup_two_a: assert property (
        take_seq |=> setup_seq)
        else $error("setup did not take two cycles");

    last_shift_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.cnt == 6'h01)
        |=> done && (state_reg.st == ST_IDLE) && (state_reg.cnt == 6'h00))
        else $error("shift did not end on last count");

    count_down_a: assert property (
        (state_reg.st == ST_SHIFT) |=> (state_reg.cnt == $past(state_reg.cnt) - 6'h01))
        else $error("count not reduced by one per shift");

    ars_sign_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.op == OP_ARS)
        |=> (state_reg.acc[23:22] == {2{$past(state_reg.acc[23])}})
            && (state_reg.ext[23] == $past(state_reg.acc[0])))
        else $error("arithmetic right lost sign or chain");

    rrot_ring_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.op == OP_RROT)
        |=> (state_reg.acc[23] == $past(state_reg.ext[0]))
            && (state_reg.ext[23] == $past(state_reg.acc[0])))
        else $error("right rotate broke the ring");

    lrot_ring_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.op == OP_LROT)
        |=> (state_reg.ext[0] == $past(state_reg.acc[23]))
            && (state_reg.acc[0] == $past(state_reg.ext[23])))
        else $error("left rotate broke the ring");

    lsh_overflow_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.op == OP_LSH)
        && (state_reg.acc[22] != state_reg.sign)
        |=> overflow_flag && state_reg.stat[`DLSN_STAT_OVF] && (state_reg.ext[0] == 1'b0))
        else $error("left shift missed overflow");

    norm_index_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.op == OP_NORM)
        |=> (state_reg.idx == $past(state_reg.idx) - 24'h000001))
        else $error("normalize did not count index down");

    norm_stop_a: assert property (
        (state_reg.st == ST_SHIFT) && (state_reg.op == OP_NORM)
        && dlsn_is_norm(step_acc) |=> done && !busy)
        else $error("normalize ran past normalized pair");

    irq_level_a: assert property (
        irq == (|(state_reg.stat & state_reg.mask)))
        else $error("interrupt not raised for unmasked status");

endmodule

`default_nettype wire

// >>> testbench/dlsn_seq_model.sv
/*
 * Instruction sequencer model that issues shift requests to the unit.
 * Assumes one clock; the unit answers with busy and a one-cycle done.
 */
`timescale 1ns/1ps
`default_nettype none

module dlsn_seq_model
(
    // Clock
    input  wire logic        clk_sys,
    // Request
    output logic             start,
    output logic [5:0]       opcode,
    output logic [13:0]      addr_field,
    output logic             indexed,
    output logic             indirect,
    output logic [13:0]      indirect_word,
    // Answer
    input  wire logic        busy,
    input  wire logic        done
);
    initial
    begin
        start         = 1'b0;
        opcode        = 6'h00;
        addr_field    = 14'h0000;
        indexed       = 1'b0;
        indirect      = 1'b0;
        indirect_word = 14'h0000;
    end

    // One request; cyc is the done cycle, bad counts busy slips
    task automatic run(input logic [5:0] opc, input logic [13:0] af, input logic ix,
                       input logic ir, input logic [13:0] iw, output int cyc, output int bad);
        cyc = 0;
        bad = 0;
        @(posedge clk_sys);
        start         <= 1'b1;
        opcode        <= opc;
        addr_field    <= af;
        indexed       <= ix;
        indirect      <= ir;
        indirect_word <= iw;
        @(posedge clk_sys);
        start         <= 1'b0;
        // Released fields carry junk so a late sample shows
        opcode        <= ~opc;
        addr_field    <= ~af;
        indirect_word <= ~iw;
        for (int k = 1; k < 200 && cyc == 0; k++)
        begin
            #1;
            if (done === 1'b1)
            begin
                cyc = k;
                if (busy !== 1'b0) bad++;
            end
            else if (busy !== 1'b1)
                bad++;
            if (cyc == 0) @(posedge clk_sys);
        end
    endtask
endmodule

`default_nettype wire

// >>> testbench/tb.sv
/*
 * Self-checking bench: random and corner shifts through the sequencer
 * model, then register and interrupt checks.
 * Assumes dlsn_regs.svh on the include path and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dlsn_regs.svh"

module tb;
    logic        clk_sys, rst_n, start, indexed, indirect, busy, done;
    logic        overflow_flag, wr_en, rd_en, irq, ix, ir, ov;
    logic [5:0]  opcode, c, ce, opc;
    logic [13:0] addr_field, indirect_word, af, iw;
    logic [7:0]  reg_addr;
    logic [23:0] wr_data, rd_data, a, b, x, v, w;
    logic [47:0] p;
    logic [1:0]  m;
    int          errors, cmp_count, k, n, cyc, bad;
    integer      seed;

    dlsn_unit u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .opcode(opcode),
        .addr_field(addr_field), .indexed(indexed), .indirect(indirect),
        .indirect_word(indirect_word), .busy(busy), .done(done),
        .overflow_flag(overflow_flag), .reg_addr(reg_addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq));
    dlsn_seq_model u_seq (.clk_sys(clk_sys), .start(start), .opcode(opcode),
        .addr_field(addr_field), .indexed(indexed), .indirect(indirect),
        .indirect_word(indirect_word), .busy(busy), .done(done));

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Expectation, compares and bus tasks
    // ------------------------------------------------------------------
    function automatic int model(input int op, input logic [5:0] cn, inout logic [47:0] q,
                                 inout logic [23:0] xi, output logic of);
        int   r;
        logic s;
        r  = 0;
        s  = q[47];
        of = 1'b0;
        for (int i = 0; i < 64; i++)
        begin
            // Normalize stops once bit 22 leaves the sign
            if (i < cn && op < 5 && !(op == 4 && q[46] != q[47]))
            begin
                case (op)
                    0: q = {q[47], q[47:1]};
                    1: q = {q[0], q[47:1]};
                    3: q = {q[46:0], q[47]};
                    default: q = {q[46:0], 1'b0};
                endcase
                if (op == 2 && q[47] != s) of = 1'b1;
                if (op == 4) xi = xi - 24'h1;
                r++;
            end
        end
        return r;
    endfunction

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_time(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] ad, input logic [23:0] d);
        @(posedge clk_sys);
        reg_addr <= ad;
        wr_data  <= d;
        wr_en    <= 1'b1;
        @(posedge clk_sys);
        wr_en    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] ad, output logic [23:0] d);
        @(posedge clk_sys);
        reg_addr <= ad;
        rd_en    <= 1'b1;
        @(posedge clk_sys);
        rd_en    <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic stop_test;
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        errors    = 0;
        cmp_count = 0;
        seed      = 32'h5a7b;
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        wr_data   = 24'h0;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset contents, last slot unmapped
        for (int r = 0; r < 7; r++)
        begin
            reg_rd(8'(r * 4), v);
            chk_word(v, 24'h0);
        end
        // Every method and refused form, counts 0, 48, 63 among random ones
        for (int i = 0; i < 70; i++)
        begin
            k   = i % 7;
            a   = 24'($random(seed));
            b   = 24'($random(seed));
            x   = 24'($random(seed));
            w   = 24'($random(seed));
            if (i % 10 == 3) {a, b} = 48'h0;
            // A zero pair gets count 61 (48 when i % 8 is 1) so the tail of zeros is exercised
            c   = (i % 8 == 0) ? 6'h00 : (i % 8 == 1) ? 6'h30 : (i % 8 == 2) ? 6'h3f
                : (i % 10 == 3) ? 6'h3d : w[23:18];
            m   = (k == 4 || k == 5) ? 2'h1 : (k == 1 || k == 3) ? 2'h2 : 2'h0;
            opc = (k == 6) ? 6'h15 : (k < 2 || k == 5) ? 6'h36 : 6'h37;
            ix  = 1'($random(seed));
            ir  = (k == 0 || k == 2) ? 1'($random(seed)) : 1'b0;
            af  = ir ? {~m, w[11:0]} : {m, w[5:0], c};
            iw  = ir ? {m, w[5:0], c} : w[13:0];
            ce  = (ix && !ir) ? c + x[5:0] : c;
            reg_wr(`DLSN_OFF_ACC, a);
            reg_wr(`DLSN_OFF_EXT, b);
            reg_wr(`DLSN_OFF_IDX, x);
            reg_wr(`DLSN_OFF_FLAG, 24'h1);
            p = {a, b};
            n = model(k, ce, p, x, ov);
            u_seq.run(opc, af, ix, ir, iw, cyc, bad);
            chk_time(cyc, n + 3);
            chk_time(bad, 0);
            reg_rd(`DLSN_OFF_ACC, v);
            chk_word(v, p[47:24]);
            reg_rd(`DLSN_OFF_EXT, v);
            chk_word(v, p[23:0]);
            reg_rd(`DLSN_OFF_IDX, v);
            chk_word(v, x);
            chk_word({23'h0, overflow_flag}, {23'h0, ov});
        end
        // Masked events stay quiet, unmasked raise, clearing drops
        reg_wr(`DLSN_OFF_MASK, 24'h0);
        reg_wr(`DLSN_OFF_STAT, 24'h3);
        reg_wr(`DLSN_OFF_FLAG, 24'h1);
        reg_wr(`DLSN_OFF_ACC, 24'h400000);
        reg_wr(`DLSN_OFF_EXT, 24'h800000);
        u_seq.run(6'h37, 14'h0001, 1'b0, 1'b0, 14'h0000, cyc, bad);
        reg_rd(`DLSN_OFF_ACC, v);
        chk_word(v, 24'h800001);
        reg_rd(`DLSN_OFF_STAT, v);
        chk_word(v, 24'h3);
        chk_word({23'h0, irq}, 24'h0);
        reg_wr(`DLSN_OFF_MASK, 24'h2);
        reg_rd(`DLSN_OFF_FLAG, v);
        chk_word(v, 24'h1);
        chk_word({23'h0, irq}, 24'h1);
        reg_wr(`DLSN_OFF_STAT, 24'h2);
        reg_rd(`DLSN_OFF_STAT, v);
        chk_word(v, 24'h1);
        chk_word({23'h0, irq}, 24'h0);
        // Read data stand for one cycle only
        @(posedge clk_sys);
        #1;
        chk_word(rd_data, 24'h0);
        stop_test();
    end

    // Cut a hang short well past the expected run
    initial
    begin
        #300000;
        errors++;
        stop_test();
    end
endmodule

`default_nettype wire
